//--- hw/mra_addressing.sv
// Phase sequencer and operand address former for memory-reference instructions.
`timescale 1ns/1ns
module mra_addressing #(
  parameter int MEM_WORDS = mra_pkg::MEM_WORDS_DEF
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [5:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  output mra_pkg::mra_mem_req_type O_MEM,
  input wire mra_pkg::mra_mem_rsp_type I_MEM
);
  import mra_pkg::*;

  function automatic logic is_mrg(input logic [15:0] iw);
    return iw[IW_OP_HI:IW_OP_LO] != OP_NON_MRG;
  endfunction

  function automatic logic is_store(input logic [15:0] iw);
    return iw[IW_OP_HI:IW_OP_LO] == OP_STORE_A;
  endfunction

  function automatic logic [15:0] page_addr(input logic [15:0] iw, input logic [14:0] cur);
    return iw[IW_PAGE_BIT] ? {1'b0, cur[14:10], iw[IW_INPAGE_HI:0]}
                           : {6'h00, iw[IW_INPAGE_HI:0]};
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  mra_state_type state, next_state;
  logic [14:0] p, next_p, m, next_m, panel_addr, next_panel_addr;
  logic [15:0] t, next_t, ir, next_ir, sp1, next_sp1, a, next_a;
  logic [15:0] panel_data, next_panel_data;
  logic run, next_run, panel_pend, next_panel_pend, exec_store, next_exec_store;
  logic bus_ack;
  logic [31:0] next_readdata;
  mra_mem_req_type next_mem;

  wire bus_req = I_AVS_READ | I_AVS_WRITE;
  wire wr_fire = I_AVS_WRITE & bus_ack;
  wire [3:0] reg_sel = I_AVS_ADDRESS[5:2];
  wire [31:0] ctrl_word = {30'h0000_0000, panel_pend, run};
  wire [31:0] wr_merged_pc = merge_be({17'h0_0000, p}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
  wire [31:0] wr_merged_a = merge_be({16'h0000, a}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
  wire [31:0] wr_merged_pa = merge_be({17'h0_0000, panel_addr}, I_AVS_WRITEDATA,
                                      I_AVS_BYTEENABLE);
  wire [31:0] wr_merged_pd = merge_be({16'h0000, panel_data}, I_AVS_WRITEDATA,
                                      I_AVS_BYTEENABLE);
  wire [31:0] wr_merged_ctrl = merge_be(ctrl_word, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);

  wire in_mem = (state == S_FETCH_MEM) | (state == S_IND_MEM) | (state == S_EXEC_MEM);
  wire addr_absent = {2'b00, m} >= 17'(MEM_WORDS);
  wire addr_acc = m == PC_RST;
  wire local_acc = addr_absent | addr_acc;
  wire mem_done = in_mem & (local_acc | (O_MEM.req & I_MEM.ack));
  wire wr_cycle = (state == S_EXEC_MEM) & exec_store;
  wire [15:0] rd_word = addr_acc ? a : (addr_absent ? WORD_RST : I_MEM.rdata);
  wire [15:0] dec_addr = page_addr(t, m);
  wire mrg_now = is_mrg(t);

  mra_phase_type phase;
  assign phase = (state == S_IND_MEM) ? PH_INDIRECT :
                 ((state == S_EXEC_MEM) | (state == S_EXEC_DONE)) ? PH_EXECUTE : PH_FETCH;

  assign O_AVS_WAITREQUEST = bus_req & ~bus_ack;

  always_comb begin
    unique case (reg_sel)
      REG_CTRL: next_readdata = ctrl_word;
      REG_STATUS: next_readdata = {28'h000_0000, O_MEM.req, 1'b0, phase};
      REG_PC: next_readdata = {17'h0_0000, p};
      REG_ACC: next_readdata = {16'h0000, a};
      REG_INSTR: next_readdata = {16'h0000, ir};
      REG_MADDR: next_readdata = {17'h0_0000, m};
      REG_PANEL_ADDR: next_readdata = {17'h0_0000, panel_addr};
      REG_PANEL_DATA: next_readdata = {16'h0000, panel_data};
      REG_SCRATCH1: next_readdata = {16'h0000, sp1};
      default: next_readdata = BUS_ZERO;
    endcase
  end

  always_comb begin
    next_state = state;
    next_p = p;
    next_m = m;
    next_t = t;
    next_ir = ir;
    next_sp1 = sp1;
    next_a = a;
    next_run = run;
    next_panel_pend = panel_pend;
    next_exec_store = exec_store;
    next_panel_addr = panel_addr;
    next_panel_data = panel_data;
    if (wr_fire) begin
      unique case (reg_sel)
        REG_CTRL: begin
          next_run = wr_merged_ctrl[CTRL_RUN_BIT];
          next_panel_pend = panel_pend | wr_merged_ctrl[CTRL_PANEL_BIT];
        end
        REG_PC: next_p = wr_merged_pc[14:0];
        REG_ACC: next_a = wr_merged_a[15:0];
        REG_PANEL_ADDR: next_panel_addr = wr_merged_pa[14:0];
        REG_PANEL_DATA: next_panel_data = wr_merged_pd[15:0];
        default: next_run = run;
      endcase
    end
    unique case (state)
      S_FETCH_ADDR: begin
        if (panel_pend) begin
          next_m = panel_addr;
          next_t = panel_data;
          next_exec_store = 1'b1;
          next_panel_pend = wr_fire & (reg_sel == REG_CTRL) & wr_merged_ctrl[CTRL_PANEL_BIT];
          next_state = S_EXEC_MEM;
        end else if (run) begin
          next_m = p;
          next_state = S_FETCH_MEM;
        end
      end
      S_FETCH_MEM: begin
        if (mem_done) begin
          next_t = rd_word;
          next_state = S_FETCH_DEC;
        end
      end
      S_FETCH_DEC: begin
        next_ir = t;
        next_p = p + 15'h0001;
        next_exec_store = mrg_now & is_store(t);
        if (mrg_now) begin
          next_sp1 = dec_addr;
          next_m = dec_addr[14:0];
          if (is_store(t)) begin
            next_t = a;
          end
        end
        if (!mrg_now) begin
          next_state = S_EXEC_DONE;
        end else if (t[IW_INDIRECT_BIT]) begin
          next_state = S_IND_MEM;
        end else begin
          next_state = S_EXEC_MEM;
        end
      end
      S_IND_MEM: begin
        if (mem_done) begin
          next_sp1 = rd_word;
          next_m = rd_word[14:0];
          if (!rd_word[IW_INDIRECT_BIT]) begin
            next_state = S_EXEC_MEM;
            if (exec_store) begin
              next_t = a;
            end
          end
        end
      end
      S_EXEC_MEM: begin
        if (mem_done) begin
          next_state = S_EXEC_DONE;
          if (exec_store) begin
            if (addr_acc) begin
              next_a = t;
            end
          end else begin
            next_t = rd_word;
            if (ir[IW_OP_HI:IW_OP_LO] == OP_LOAD_A) begin
              next_a = rd_word;
            end
          end
        end
      end
      S_EXEC_DONE: next_state = S_FETCH_ADDR;
    endcase
  end

  always_comb begin
    next_mem = O_MEM;
    if (in_mem & ~local_acc & ~O_MEM.req) begin
      next_mem.req = 1'b1;
      next_mem.we = wr_cycle;
      next_mem.addr = m;
      next_mem.stack = m[MA_STACK_HI:MA_STACK_LO];
      next_mem.module_sel = m[MA_MODULE_BIT];
      next_mem.wdata = t;
    end else if (I_MEM.ack) begin
      next_mem.req = 1'b0;
      next_mem.we = 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      state <= S_FETCH_ADDR;
      p <= PC_RST;
      m <= PC_RST;
      panel_addr <= PC_RST;
      {t, ir, sp1, a, panel_data} <= {5{WORD_RST}};
      {run, panel_pend, exec_store, bus_ack} <= 4'h0;
      O_MEM <= '0;
      O_AVS_READDATA <= BUS_ZERO;
    end else begin
      state <= next_state;
      {p, m, panel_addr} <= {next_p, next_m, next_panel_addr};
      {t, ir, sp1, a, panel_data} <= {next_t, next_ir, next_sp1, next_a, next_panel_data};
      {run, panel_pend, exec_store} <= {next_run, next_panel_pend, next_exec_store};
      bus_ack <= bus_req & ~bus_ack;
      O_MEM <= next_mem;
      if (I_AVS_READ & ~bus_ack) begin
        O_AVS_READDATA <= next_readdata;
      end
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  a_fetch_first_pc: assert property (
    state == S_FETCH_ADDR && run && !panel_pend |=> state == S_FETCH_MEM && m == $past(p))
    else $error("fetch first step did not address the program counter");
  a_direct_to_exec: assert property (
    state == S_FETCH_DEC && mrg_now && !t[15] |=> state == S_EXEC_MEM)
    else $error("direct instruction did not enter execute");
  a_indirect_entry: assert property (
    state == S_FETCH_DEC && mrg_now && t[15] |=> state == S_IND_MEM)
    else $error("indirect instruction did not enter indirect phase");
  a_page_zero_clear: assert property (
    state == S_FETCH_DEC && mrg_now && !t[10] |=> sp1[15:10] == 6'h00 && m[14:10] == 5'h00)
    else $error("page zero reference kept upper bits");
  a_current_page_keep: assert property (
    state == S_FETCH_DEC && mrg_now && t[10] |=> m[14:10] == $past(m[14:10]))
    else $error("current page bits changed");
  a_inpage_copy: assert property (
    state == S_FETCH_DEC && mrg_now |=> sp1[9:0] == $past(t[9:0]) && m[9:0] == sp1[9:0])
    else $error("in-page address not routed through scratch one");
  a_instr_load: assert property (
    state == S_FETCH_DEC |=> ir == $past(t))
    else $error("instruction register not loaded unchanged");
  a_instr_only_fetch: assert property (
    state != S_FETCH_DEC |=> $stable(ir))
    else $error("instruction register changed outside fetch");
  a_pc_increment: assert property (
    state == S_FETCH_DEC |=> p == $past(p) + 15'h0001 && phase != PH_FETCH)
    else $error("program counter not incremented at end of fetch");
  a_pc_wrap: assert property (
    state == S_FETCH_DEC && p == 15'h7FFF |=> p == PC_RST)
    else $error("program counter did not wrap to zero");
  a_indirect_chain: assert property (
    state == S_IND_MEM && mem_done |=> m == $past(rd_word[14:0]) &&
      (state == S_IND_MEM) == $past(rd_word[15]))
    else $error("indirect word not followed correctly");
  a_store_inhibit: assert property (
    state == S_EXEC_MEM && exec_store && mem_done |=> t == $past(t))
    else $error("clear-write loaded old contents");
  a_write_half: assert property (
    O_MEM.req && state == S_EXEC_MEM && exec_store |-> O_MEM.we && O_MEM.wdata == t)
    else $error("write half does not carry the data register");
  a_panel_store: assert property (
    state == S_FETCH_ADDR && panel_pend |=> state == S_EXEC_MEM && exec_store &&
      t == $past(panel_data))
    else $error("panel data did not take the clear-write path");
  a_absent_zero: assert property (
    in_mem && addr_absent |-> mem_done && rd_word == WORD_RST && !O_MEM.req)
    else $error("absent memory did not read as zero");
  a_stack_module: assert property (
    O_MEM.req |-> O_MEM.stack == O_MEM.addr[14:13] && O_MEM.module_sel == O_MEM.addr[12])
    else $error("stack or module select wrong");
  a_reset_fetch: assert property (@(posedge I_CORE_CLK) disable iff (1'b0)
    $past(I_RST) && !I_RST |-> state == S_FETCH_ADDR && phase == PH_FETCH)
    else $error("reset did not return to fetch");
  a_bus_answer: assert property (
    bus_req |-> ##[0:1] !O_AVS_WAITREQUEST)
    else $error("bus answer late");
  a_req_hold: assert property (
    O_MEM.req && !I_MEM.ack |=> O_MEM.req && $stable(O_MEM.addr) && $stable(O_MEM.wdata))
    else $error("memory request dropped before its answer");
  a_req_release: assert property (
    O_MEM.req && I_MEM.ack |=> !O_MEM.req)
    else $error("memory request not released after its answer");
  a_load_operand: assert property (
    state == S_EXEC_MEM && mem_done && !exec_store && ir[14:11] == OP_LOAD_A |=>
      a == $past(rd_word))
    else $error("load did not take the operand word");
  a_nop_execute: assert property (
    state == S_FETCH_DEC && !mrg_now |=> state == S_EXEC_DONE && $stable(m))
    else $error("zero word did not execute as a no-operation");
  a_acc_location: assert property (
    in_mem && addr_acc |-> mem_done && rd_word == a && !O_MEM.req)
    else $error("location zero did not map to the accumulator");
  a_store_entry: assert property (
    state == S_FETCH_DEC && mrg_now && is_store(t) |=> exec_store && t == $past(a))
    else $error("store did not load the data register");
  a_store_word: assert property (
    state == S_EXEC_MEM && exec_store && addr_acc |=> a == $past(t))
    else $error("store to location zero did not reach the accumulator");
  a_panel_clear: assert property (
    state == S_FETCH_ADDR && panel_pend && !wr_fire |=> !panel_pend)
    else $error("panel request not cleared when accepted");
  a_fetch_read: assert property (
    state == S_FETCH_MEM && O_MEM.req |-> !O_MEM.we && O_MEM.addr == m)
    else $error("fetch request is not a read of the address register");

  c_indirect_chain: cover property (state == S_IND_MEM && mem_done && rd_word[15]);
  c_store_exec: cover property (state == S_EXEC_MEM && exec_store && mem_done);
  c_panel_store: cover property (state == S_FETCH_ADDR && panel_pend);
  c_absent_read: cover property (state == S_FETCH_MEM && addr_absent);
  c_current_page: cover property (state == S_FETCH_DEC && mrg_now && t[IW_PAGE_BIT]);
endmodule

//--- hw/mra_pkg.sv
// Shared constants, types and register map of the memory-reference addressing block.
package mra_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int MEM_WORDS_DEF = 32768;
  localparam int IW_INDIRECT_BIT = 15;
  localparam int IW_PAGE_BIT = 10;
  localparam int IW_OP_HI = 14;
  localparam int IW_OP_LO = 11;
  localparam int IW_INPAGE_HI = 9;
  localparam int MA_STACK_HI = 14;
  localparam int MA_STACK_LO = 13;
  localparam int MA_MODULE_BIT = 12;
  localparam logic [3:0] OP_NON_MRG = 4'h0;
  localparam logic [3:0] OP_LOAD_A = 4'h6;
  localparam logic [3:0] OP_STORE_A = 4'h7;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_PC = 4'h2;
  localparam logic [3:0] REG_ACC = 4'h3;
  localparam logic [3:0] REG_INSTR = 4'h4;
  localparam logic [3:0] REG_MADDR = 4'h5;
  localparam logic [3:0] REG_PANEL_ADDR = 4'h6;
  localparam logic [3:0] REG_PANEL_DATA = 4'h7;
  localparam logic [3:0] REG_SCRATCH1 = 4'h8;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_PANEL_BIT = 1;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

  typedef enum {
    S_FETCH_ADDR,
    S_FETCH_MEM,
    S_FETCH_DEC,
    S_IND_MEM,
    S_EXEC_MEM,
    S_EXEC_DONE
  } mra_state_type;

  typedef enum logic [1:0] {
    PH_FETCH,
    PH_INDIRECT,
    PH_EXECUTE
  } mra_phase_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] stack;
    logic module_sel;
    logic [14:0] addr;
    logic [15:0] wdata;
  } mra_mem_req_type;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } mra_mem_rsp_type;
endpackage

//--- tb/mra_mem_model.sv
// Behavioural core memory that answers the addressing block's requests.
`timescale 1ns/1ns
module mra_mem_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire mra_pkg::mra_mem_req_type i_req,
  output mra_pkg::mra_mem_rsp_type o_rsp
);
  import mra_pkg::*;
  logic [15:0] words [0:32767];
  mra_mem_req_type log_q[$];
  int lat = 0;
  int cnt = 0;
  initial begin
    o_rsp = '0;
    foreach (words[i]) words[i] = 16'h0000;
  end
  always @(posedge i_clk) begin
    o_rsp.ack <= 1'b0;
    o_rsp.rdata <= ~o_rsp.rdata;
    if (i_rst) begin
      cnt <= 0;
    end else if (i_req.req && !o_rsp.ack) begin
      if (cnt >= lat) begin
        cnt <= 0;
        o_rsp.ack <= 1'b1;
        log_q.push_back(i_req);
        if (i_req.we) begin
          words[i_req.addr] <= i_req.wdata;
        end else begin
          o_rsp.rdata <= words[i_req.addr];
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

//--- tb/mra_addressing_tb.sv
// Self-checking testbench of the memory-reference addressing block.
`timescale 1ns/1ns
module mra_addressing_tb;
  import mra_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wait_req;
  logic [31:0] v;
  mra_mem_req_type mreq;
  mra_mem_rsp_type mrsp;
  int failures = 0;
  int cmp_count = 0;

  always #4 clk = ~clk;

  mra_addressing #(.MEM_WORDS(16384)) uut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hF),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_req), .O_MEM(mreq), .I_MEM(mrsp)
  );
  mra_mem_model mem (.i_clk(clk), .i_rst(rst), .i_req(mreq), .o_rsp(mrsp));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {idx, 2'b00};
    wdat <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wait_req !== 1'b0 && n < 100) begin
      n++;
      @(posedge clk);
    end
    if (wait_req !== 1'b0) failures++;
    v = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk(v, exp);
  endtask

  task automatic lchk(input int i, input logic we, input logic [14:0] a, input logic [15:0] d);
    mra_mem_req_type e;
    e = mem.log_q[i];
    chk({16'h0000, e.we, e.addr}, {16'h0000, we, a});
    chk({29'h0000_0000, e.stack, e.module_sel}, {29'h0000_0000, a[14:12]});
    if (we) chk({16'h0000, e.wdata}, {16'h0000, d});
  endtask

  task automatic wait_log(input int n);
    int k;
    k = 0;
    while (mem.log_q.size() < n && k < 500) begin
      k++;
      @(posedge clk);
    end
    if (mem.log_q.size() < n) failures++;
  endtask

  task automatic run_prog(input logic [14:0] pc, input int n, input int lat);
    int k;
    mem.lat = lat;
    mem.log_q.delete();
    bus(1'b1, REG_PC, {17'h0_0000, pc});
    bus(1'b1, REG_CTRL, 32'h0000_0001);
    wait_log(n);
    bus(1'b1, REG_CTRL, 32'h0000_0000);
    k = 0;
    v = 32'h0000_000F;
    while ((v[3] || v[1:0] != 2'd0) && k < 50) begin
      k++;
      bus(1'b0, REG_STATUS, 32'h0000_0000);
    end
    if (v[3] || v[1:0] != 2'd0) failures++;
  endtask

  task automatic t_reset();
    rchk(REG_STATUS, 32'h0000_0000);
    rchk(REG_PC, 32'h0000_0000);
    bus(1'b1, REG_INSTR, 32'h0000_FFFF);
    rchk(REG_INSTR, 32'h0000_0000);
    bus(1'b1, 4'h9, 32'h0000_1234);
    rchk(4'h9, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_direct();
    mem.words[15'h1400] = 16'h33F0;
    mem.words[15'h03F0] = 16'h1234;
    run_prog(15'h1400, 3, 0);
    lchk(0, 1'b0, 15'h1400, 16'h0000);
    lchk(1, 1'b0, 15'h03F0, 16'h0000);
    lchk(2, 1'b0, 15'h1401, 16'h0000);
    rchk(REG_ACC, 32'h0000_1234);
    rchk(REG_SCRATCH1, 32'h0000_03F0);
    $display("test direct_page_zero done");
  endtask

  task automatic t_indirect();
    mem.words[15'h2C10] = 16'hB420;
    mem.words[15'h2C20] = 16'hB123;
    mem.words[15'h3123] = 16'h0456;
    mem.words[15'h0456] = 16'hBEEF;
    run_prog(15'h2C10, 5, 3);
    lchk(1, 1'b0, 15'h2C20, 16'h0000);
    lchk(2, 1'b0, 15'h3123, 16'h0000);
    lchk(3, 1'b0, 15'h0456, 16'h0000);
    lchk(4, 1'b0, 15'h2C11, 16'h0000);
    rchk(REG_ACC, 32'h0000_BEEF);
    rchk(REG_SCRATCH1, 32'h0000_0456);
    $display("test indirect_chain done");
  endtask

  task automatic t_store();
    bus(1'b1, REG_ACC, 32'h0000_A5C3);
    mem.words[15'h0100] = 16'h3877;
    mem.words[15'h0077] = 16'h1111;
    run_prog(15'h0100, 2, 1);
    lchk(1, 1'b1, 15'h0077, 16'hA5C3);
    chk({16'h0000, mem.words[15'h0077]}, 32'h0000_A5C3);
    $display("test store done");
  endtask

  task automatic t_panel();
    mem.log_q.delete();
    bus(1'b1, REG_PANEL_ADDR, 32'h0000_0300);
    bus(1'b1, REG_PANEL_DATA, 32'h0000_5A5A);
    bus(1'b1, REG_CTRL, 32'h0000_0002);
    wait_log(1);
    lchk(0, 1'b1, 15'h0300, 16'h5A5A);
    rchk(REG_CTRL, 32'h0000_0000);
    rchk(REG_MADDR, 32'h0000_0300);
    chk({16'h0000, mem.words[15'h0300]}, 32'h0000_5A5A);
    $display("test panel_store done");
  endtask

  task automatic t_absent();
    bus(1'b1, REG_ACC, 32'h0000_3005);
    mem.words[15'h0005] = 16'h7777;
    run_prog(15'h7FFE, 1, 0);
    lchk(0, 1'b0, 15'h0005, 16'h0000);
    rchk(REG_ACC, 32'h0000_7777);
    $display("test absent_memory done");
  endtask

  task automatic t_rerst();
    mem.lat = 6;
    bus(1'b1, REG_PC, 32'h0000_0200);
    bus(1'b1, REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(REG_STATUS, 32'h0000_0000);
    rchk(REG_PC, 32'h0000_0000);
    chk({31'h0000_0000, mreq.req}, 32'h0000_0000);
    $display("test mid_run_reset done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_direct();
    t_indirect();
    t_store();
    t_panel();
    t_absent();
    t_rerst();
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule
